// ==== logic/cc_channel.sv ====
// One input-capture / output-compare channel with its 16-bit value register
`timescale 1ns/1ps
`include "timer_cc_map.svh"
module cc_channel import timer_cc_pkg::*; (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Configuration and time base
   input wire ch_cfg_t cfg_i,
   input wire time_base_t tb_i,
   // Pin level
   input wire logic pin_i,
   // Software write
   input wire logic wr_i,
   input wire logic [15:0] wdata_i,
   // Results
   output logic [15:0] value_o,
   output logic cap_o,
   output logic match_o
);

   logic [15:0] value_r;
   logic pin_d_r;
   logic rise_w;
   logic fall_w;
   logic edge_hit_w;

   assign rise_w = pin_i & ~pin_d_r;
   assign fall_w = ~pin_i & pin_d_r;
   assign edge_hit_w = (cfg_i.edge_sel == EDGE_RISE) ? rise_w :
                       (cfg_i.edge_sel == EDGE_FALL) ? fall_w :
                       (cfg_i.edge_sel == EDGE_ANY) ? (rise_w | fall_w) : 1'b0;
   assign cap_o = cfg_i.enable & ~cfg_i.is_cmp & edge_hit_w;
   // Match on the count being entered, so the action lines up with the new count
   assign match_o = cfg_i.is_cmp & tb_i.tick & (tb_i.cnt_nxt == value_r);
   assign value_o = value_r;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         value_r <= `RST_WORD;
         pin_d_r <= 1'b0;
      end else begin
         pin_d_r <= pin_i;
         if (cap_o) begin
            value_r <= tb_i.cnt;
         end else if (wr_i) begin
            value_r <= wdata_i;
         end
      end
   end

endmodule

// ==== logic/timer_cc.sv ====
// Timer with prescaler, six capture/compare channels and pulse accumulator, APB slave
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "timer_cc_map.svh"
module timer_cc import timer_cc_pkg::*; #(
   parameter int PRE_STAGES = `PRE_STAGES_DEF,
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Operating modes
   input wire logic stop_mode_i,
   input wire logic freeze_mode_i,
   input wire logic wait_mode_i,
   input wire logic test_mode_i,
   // Channel pins 2..7
   input wire logic [5:0] ch_pin_i,
   output logic [5:0] ch_pin_o,
   output logic [5:0] ch_pin_oe_o,
   // Interrupt
   output logic irq_o
);

   // Refuse sizes the logic cannot serve: the prescale select masks up to seven stages,
   // the accumulator taps six, and the decode needs index bits up to the top register
   if (PRE_STAGES < 7) begin : g_bad_pre
      $error("prescaler needs at least seven stages");
   end
   if (ADDR_W < 8) begin : g_bad_addr
      $error("address must reach index 0x23");
   end

   // Software registers
   logic [7:2] dir_r;
   logic [7:2] ovr_mask_r;
   logic [7:2] ovr_data_r;
   logic [7:4] sctl1_r;
   logic [7:2] tog_ovf_r;
   logic [15:4] act_r;
   logic [15:4] edg_r;
   logic [7:0] irq_en_r;
   logic [4:0] sctl2_r;
   logic [7:2] ch_flg_r;
   logic ovf_flg_r;
   logic [6:0] pa_ctl_r;
   logic [1:0] pa_flg_r;
   // Timer state
   logic [PRE_STAGES-1:0] pre_r;
   logic [15:0] cnt_r;
   logic [15:0] pa_cnt_r;
   logic pa_pin_d_r;
   logic [5:0] pin_r;
   logic [5:0] oe_r;
   // Bus and interrupt outputs
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_r;

   // Bus decode
   logic [5:0] idx_w;
   logic setup_w;
   logic wr_w;
   logic unmapped_w;
   logic tc_hit_w;
   logic [2:0] tc_sel_w;
   logic [5:0] tc_off_w;
   logic [31:0] rd_w;
   logic [31:0] tc_rd_w;

   assign idx_w = paddr_i[7:2];
   assign setup_w = psel_i & ~penable_i;
   // A refused address must never alias onto a mapped register
   assign wr_w = psel_i & penable_i & pwrite_i & pready_r & ~unmapped_w;
   assign tc_hit_w = (idx_w >= `IDX_TC_FIRST) && (idx_w <= `IDX_TC_LAST);
   assign tc_off_w = idx_w - `IDX_TC_FIRST;
   assign tc_sel_w = tc_off_w[3:1];
   // Unused low address bits must be zero; indices above 0x23 and the reserved gap 0x10..0x13 are refused
   assign unmapped_w = (paddr_i[1:0] != 2'b00) | (paddr_i[ADDR_W-1:2] > ADDR_W'(`IDX_PA_LO)) |
                       ((idx_w >= `IDX_RSV_FIRST) && (idx_w < `IDX_TC_FIRST));

   // Mode gating
   logic halt_w;
   logic run_w;
   logic pa_run_w;
   assign halt_w = stop_mode_i | (wait_mode_i & sctl1_r[`BIT_WAI]);
   assign run_w = sctl1_r[`BIT_TEN] & ~halt_w & ~(freeze_mode_i & sctl1_r[`BIT_FRZ]);
   assign pa_run_w = pa_ctl_r[`BIT_PAEN] & ~halt_w;

   // Prescaler
   logic [PRE_STAGES-1:0] pre_mask_w;
   logic tick_w;
   logic div64_w;
   assign pre_mask_w = PRE_STAGES'((8'h01 << sctl2_r[2:0]) - 8'h01);
   assign tick_w = run_w & ((pre_r & pre_mask_w) == pre_mask_w);
   // Gated accumulation relies on the prescaler, so it dies with the timer
   assign div64_w = run_w & (pre_r[`PA_DIV_BITS-1:0] == {`PA_DIV_BITS{1'b1}});

   // Counter
   logic [15:0] val_w [6];
   logic [5:0] cap_w;
   logic [5:0] match_w;
   logic tcre_hit_w;
   logic [15:0] cnt_nxt_w;
   logic ovf_w;
   time_base_t tb_w;
   assign tcre_hit_w = sctl2_r[`BIT_TCRE] & dir_r[7] & (cnt_r == val_w[5]);
   assign cnt_nxt_w = tcre_hit_w ? 16'h0000 : cnt_r + 16'h0001;
   assign ovf_w = tick_w & (cnt_r == 16'hffff);
   assign tb_w = '{cnt: cnt_r, cnt_nxt: cnt_nxt_w, tick: tick_w};

   // Force and overrides
   logic [7:2] frc_w;
   logic ch7_ev_w;
   logic [5:0] pin_nxt_w;
   logic [5:0] oe_nxt_w;
   logic [7:2] flg_set_w;
   assign frc_w = (wr_w && idx_w == `IDX_FORCE) ? pwdata_i[7:2] : 6'h00;
   assign ch7_ev_w = dir_r[7] & (frc_w[7] | match_w[5]);

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_ch
         localparam int C = gi + `FIRST_CH;
         ch_cfg_t cfg_w;
         out_act_t act_w;
         logic ev_w;
         logic lvl_w;
         logic tog_w;
         assign cfg_w = '{enable: ~stop_mode_i, is_cmp: dir_r[C], edge_sel: edge_mode_t'(edg_r[2*C+1 -: 2])};
         assign act_w = out_act_t'(act_r[2*C+1 -: 2]);
         assign ev_w = dir_r[C] & (frc_w[C] | match_w[gi]);
         assign tog_w = pin_r[gi] ^ (ovf_w & tog_ovf_r[C]);
         assign lvl_w = ~ev_w ? tog_w :
                        (act_w == ACT_TOGGLE) ? ~pin_r[gi] :
                        (act_w == ACT_CLEAR) ? 1'b0 :
                        (act_w == ACT_SET) ? 1'b1 : tog_w;
         assign pin_nxt_w[gi] = (ch7_ev_w & ovr_mask_r[C] & dir_r[C]) ? ovr_data_r[C] : lvl_w;
         assign oe_nxt_w[gi] = dir_r[C] & ((act_w != ACT_NONE) | ovr_mask_r[C]) &
                               ~((C == 7) & pa_ctl_r[`BIT_PAEN]);
         // Forced action never sets the flag, even with a real match alongside
         assign flg_set_w[C] = cap_w[gi] | (match_w[gi] & ~frc_w[C]);
         cc_channel u_ch (
            .ref_clk_i(ref_clk_i),
            .sys_rst_i(sys_rst_i),
            .cfg_i(cfg_w),
            .tb_i(tb_w),
            .pin_i(ch_pin_i[gi]),
            .wr_i(wr_w && idx_w == `IDX_TC_FIRST + 6'(2 * gi)),
            .wdata_i(pwdata_i[15:0]),
            .value_o(val_w[gi]),
            .cap_o(cap_w[gi]),
            .match_o(match_w[gi])
         );
      end
   endgenerate

   // Pulse accumulator on channel 7 pin
   logic pa_rise_w;
   logic pa_fall_w;
   logic pa_edge_w;
   logic pa_gate_w;
   logic pa_inc_w;
   assign pa_rise_w = ch_pin_i[5] & ~pa_pin_d_r;
   assign pa_fall_w = ~ch_pin_i[5] & pa_pin_d_r;
   // Same edge ends a gate and counts an event, so one select serves both modes
   assign pa_edge_w = pa_run_w & (pa_ctl_r[`BIT_PEDGE] ? pa_rise_w : pa_fall_w);
   assign pa_gate_w = pa_ctl_r[`BIT_PEDGE] ? ~ch_pin_i[5] : ch_pin_i[5];
   assign pa_inc_w = pa_ctl_r[`BIT_PAMOD] ? (pa_run_w & div64_w & pa_gate_w) : pa_edge_w;

   // Read mux
   assign tc_rd_w = tc_off_w[0] ? {24'h0, val_w[tc_sel_w][7:0]} : {16'h0, val_w[tc_sel_w]};
   assign rd_w = (idx_w == `IDX_DIR) ? {24'h0, dir_r, 2'b00} :
                 (idx_w == `IDX_OVR_MASK) ? {24'h0, ovr_mask_r, 2'b00} :
                 (idx_w == `IDX_OVR_DATA) ? {24'h0, ovr_data_r, 2'b00} :
                 (idx_w == `IDX_CNT_HI) ? {16'h0, cnt_r} :
                 (idx_w == `IDX_CNT_LO) ? {24'h0, cnt_r[7:0]} :
                 (idx_w == `IDX_SCTL1) ? {24'h0, sctl1_r, 4'h0} :
                 (idx_w == `IDX_TOG_OVF) ? {24'h0, tog_ovf_r, 2'b00} :
                 (idx_w == `IDX_ACT_HI) ? {24'h0, act_r[15:8]} :
                 (idx_w == `IDX_ACT_LO) ? {24'h0, act_r[7:4], 4'h0} :
                 (idx_w == `IDX_EDG_HI) ? {24'h0, edg_r[15:8]} :
                 (idx_w == `IDX_EDG_LO) ? {24'h0, edg_r[7:4], 4'h0} :
                 (idx_w == `IDX_IRQ_EN) ? {24'h0, irq_en_r} :
                 (idx_w == `IDX_SCTL2) ? {24'h0, sctl2_r[4], 3'h0, sctl2_r[3:0]} :
                 (idx_w == `IDX_CH_FLG) ? {24'h0, ch_flg_r, 2'b00} :
                 (idx_w == `IDX_OVF_FLG) ? {24'h0, ovf_flg_r, 7'h00} :
                 tc_hit_w ? tc_rd_w :
                 (idx_w == `IDX_PA_CTL) ? {24'h0, 1'b0, pa_ctl_r} :
                 (idx_w == `IDX_PA_FLG) ? {30'h0, pa_flg_r} :
                 (idx_w == `IDX_PA_HI) ? {16'h0, pa_cnt_r} :
                 (idx_w == `IDX_PA_LO) ? {24'h0, pa_cnt_r[7:0]} : 32'h0;

   // Write strobes
   logic wr_dir_w;
   logic wr_sctl1_w;
   logic wr_sctl2_w;
   logic wr_chflg_w;
   logic wr_ovfflg_w;
   logic wr_accumulator_flags_w;
   assign wr_dir_w = wr_w && idx_w == `IDX_DIR;
   assign wr_sctl1_w = wr_w && idx_w == `IDX_SCTL1;
   assign wr_sctl2_w = wr_w && idx_w == `IDX_SCTL2;
   assign wr_chflg_w = wr_w && idx_w == `IDX_CH_FLG;
   assign wr_ovfflg_w = wr_w && idx_w == `IDX_OVF_FLG;
   assign wr_accumulator_flags_w = wr_w && idx_w == `IDX_PA_FLG;

   // APB answer: one wait-free access phase after each setup
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= setup_w;
         pslverr_r <= setup_w & unmapped_w;
         // Data taken at setup stands through the access phase
         if (setup_w) begin
            prdata_r <= unmapped_w ? 32'h0 : rd_w;
         end
      end
   end

   // Control registers
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dir_r <= 6'h00;
         ovr_mask_r <= 6'h00;
         ovr_data_r <= 6'h00;
         sctl1_r <= 4'h0;
         tog_ovf_r <= 6'h00;
         act_r <= 12'h000;
         edg_r <= 12'h000;
         irq_en_r <= `RST_BYTE;
         sctl2_r <= 5'h00;
         pa_ctl_r <= 7'h00;
      end else if (wr_w) begin
         if (wr_dir_w) dir_r <= pwdata_i[7:2];
         if (idx_w == `IDX_OVR_MASK) ovr_mask_r <= pwdata_i[7:2];
         if (idx_w == `IDX_OVR_DATA) ovr_data_r <= pwdata_i[7:2];
         if (wr_sctl1_w) sctl1_r <= pwdata_i[7:4];
         if (idx_w == `IDX_TOG_OVF) tog_ovf_r <= pwdata_i[7:2];
         if (idx_w == `IDX_ACT_HI) act_r[15:8] <= pwdata_i[7:0];
         if (idx_w == `IDX_ACT_LO) act_r[7:4] <= pwdata_i[7:4];
         if (idx_w == `IDX_EDG_HI) edg_r[15:8] <= pwdata_i[7:0];
         if (idx_w == `IDX_EDG_LO) edg_r[7:4] <= pwdata_i[7:4];
         if (idx_w == `IDX_IRQ_EN) irq_en_r <= pwdata_i[7:0];
         if (wr_sctl2_w) sctl2_r <= {pwdata_i[7], pwdata_i[3:0]};
         if (idx_w == `IDX_PA_CTL) pa_ctl_r <= pwdata_i[6:0];
      end
   end

   // Time base and accumulator
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pre_r <= '0;
         cnt_r <= `RST_WORD;
         pa_cnt_r <= `RST_WORD;
         pa_pin_d_r <= 1'b0;
      end else begin
         pa_pin_d_r <= ch_pin_i[5];
         if (run_w) pre_r <= pre_r + 1'b1;
         // Prescaler phase is kept, so the first tick after a write may come early
         if (wr_w && idx_w == `IDX_CNT_HI && test_mode_i) begin
            cnt_r <= pwdata_i[15:0];
         end else if (tick_w) begin
            cnt_r <= cnt_nxt_w;
         end
         if (wr_w && idx_w == `IDX_PA_HI) begin
            pa_cnt_r <= pwdata_i[15:0];
         end else if (pa_inc_w) begin
            pa_cnt_r <= pa_cnt_r + 16'h0001;
         end
      end
   end

   // Sticky flags: a hardware set wins over a same-cycle write-one clear
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ch_flg_r <= 6'h00;
         ovf_flg_r <= 1'b0;
         pa_flg_r <= 2'b00;
      end else begin
         ch_flg_r <= (ch_flg_r & ~(wr_chflg_w ? pwdata_i[7:2] : 6'h00)) | flg_set_w;
         ovf_flg_r <= (ovf_flg_r & ~(wr_ovfflg_w & pwdata_i[7])) | ovf_w;
         pa_flg_r <= (pa_flg_r & ~(wr_accumulator_flags_w ? pwdata_i[1:0] : 2'b00)) |
                     {pa_inc_w & (pa_cnt_r == 16'hffff), pa_edge_w};
      end
   end

   // Pins and interrupt
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_r <= 6'h00;
         oe_r <= 6'h00;
         irq_r <= 1'b0;
      end else begin
         pin_r <= pin_nxt_w;
         oe_r <= oe_nxt_w;
         // Registered for a clean pin; trails the flags by one cycle
         irq_r <= |(ch_flg_r & irq_en_r[7:2]) | (ovf_flg_r & sctl2_r[4]) |
                  (pa_flg_r[1] & pa_ctl_r[`BIT_PAOVI]) | (pa_flg_r[0] & pa_ctl_r[`BIT_PAI]);
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign ch_pin_o = pin_r;
   assign ch_pin_oe_o = oe_r;
   assign irq_o = irq_r;

endmodule

// ==== shared/timer_cc_map.svh ====
// Register indices, field positions, reset values and counts of the capture/compare timer
`ifndef TIMER_CC_MAP_SVH
`define TIMER_CC_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_DIR 6'h00
`define IDX_FORCE 6'h01
`define IDX_OVR_MASK 6'h02
`define IDX_OVR_DATA 6'h03
`define IDX_CNT_HI 6'h04
`define IDX_CNT_LO 6'h05
`define IDX_SCTL1 6'h06
`define IDX_TOG_OVF 6'h07
`define IDX_ACT_HI 6'h08
`define IDX_ACT_LO 6'h09
`define IDX_EDG_HI 6'h0a
`define IDX_EDG_LO 6'h0b
`define IDX_IRQ_EN 6'h0c
`define IDX_SCTL2 6'h0d
`define IDX_CH_FLG 6'h0e
`define IDX_OVF_FLG 6'h0f
`define IDX_RSV_FIRST 6'h10
`define IDX_TC_FIRST 6'h14
`define IDX_TC_LAST 6'h1f
`define IDX_PA_CTL 6'h20
`define IDX_PA_FLG 6'h21
`define IDX_PA_HI 6'h22
`define IDX_PA_LO 6'h23

// Field positions
`define BIT_TEN 7
`define BIT_WAI 6
`define BIT_FRZ 5
`define BIT_TOI 7
`define BIT_TCRE 3
`define BIT_PAEN 6
`define BIT_PAMOD 5
`define BIT_PEDGE 4
`define BIT_PAOVI 1
`define BIT_PAI 0

// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

// Counts
`define PRE_STAGES_DEF 7
`define PA_DIV_BITS 6
`define FIRST_CH 2

`endif

// ==== shared/timer_cc_pkg.sv ====
// Types shared by the capture/compare timer modules
package timer_cc_pkg;

   typedef enum logic [1:0] {
      EDGE_OFF = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_ANY = 2'b11
   } edge_mode_t;

   typedef enum logic [1:0] {
      ACT_NONE = 2'b00,
      ACT_TOGGLE = 2'b01,
      ACT_CLEAR = 2'b10,
      ACT_SET = 2'b11
   } out_act_t;

   typedef struct packed {
      logic enable;
      logic is_cmp;
      edge_mode_t edge_sel;
   } ch_cfg_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] cnt_nxt;
      logic tick;
   } time_base_t;

endpackage

// ==== tb/pin_model.sv ====
// Far-side model of the six channel pins
`timescale 1ns/1ps
module pin_model (
   // Clock
   input wire logic ref_clk_i,
   // Design side
   input wire logic [5:0] ch_pin_o,
   input wire logic [5:0] ch_pin_oe_o,
   // Levels seen by the design
   output logic [5:0] ch_pin_i
);
   logic [5:0] drv_r = 6'h00;
   // Design drive wins where enabled, so a compare pin never fights us
   assign ch_pin_i = (ch_pin_oe_o & ch_pin_o) | (~ch_pin_oe_o & drv_r);
   task automatic pulse(input int ch, input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge ref_clk_i);
         drv_r[ch] <= 1'b1;
         repeat (2) @(posedge ref_clk_i);
         drv_r[ch] <= 1'b0;
         @(posedge ref_clk_i);
      end
   endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`include "timer_cc_map.svh"
module tb_top;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic stop = 1'b0;
   logic frz = 1'b0;
   logic wai = 1'b0;
   logic tst = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [5:0] pin_in;
   logic [5:0] pin_out;
   logic [5:0] pin_oe;
   logic [31:0] rdata;
   logic rerr;
   logic [15:0] lfsr_r = 16'h9a17;
   logic [15:0] v;
   int fail_count = 0;
   int checked = 0;

   always #25 ref_clk_i = ~ref_clk_i;

   timer_cc i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .stop_mode_i(stop), .freeze_mode_i(frz), .wait_mode_i(wai), .test_mode_i(tst),
      .ch_pin_i(pin_in), .ch_pin_o(pin_out), .ch_pin_oe_o(pin_oe), .irq_o(irq));
   pin_model i_pins (.ref_clk_i(ref_clk_i), .ch_pin_o(pin_out), .ch_pin_oe_o(pin_oe), .ch_pin_i(pin_in));

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] ra(input logic [5:0] idx);
      return {idx, 2'b00};
   endfunction
   function automatic logic [7:0] tc_addr(input int c);
      return ra(6'(`IDX_TC_FIRST + 2 * (c - 2)));
   endfunction

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Holds the request until ready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      // Waits without limit; only the watchdog ends a wait in which ready never comes
      do begin
         @(posedge ref_clk_i);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdata, exp);
   endtask
   // Two counter reads three cycles apart
   task automatic pair(input logic [15:0] delta);
      logic [15:0] c1;
      apb(1'b0, ra(`IDX_CNT_HI), 32'h0);
      c1 = rdata[15:0];
      rdc(ra(`IDX_CNT_HI), {16'h0, c1 + delta});
   endtask

   initial begin
      #(50 * 20000);
      fail_count++;
      final_report();
   end

   initial begin
      repeat (8) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 16; i++) rdc(ra(6'(i)), 32'h0);
      for (int i = 0; i < 4; i++) rdc(ra(6'(`IDX_PA_CTL + i)), 32'h0);
      apb(1'b0, 8'h4c, 32'h0);
      check({31'h0, rerr}, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      check({31'h0, rerr}, 32'h1);
      apb(1'b0, 8'h01, 32'h0);
      check({31'h0, rerr}, 32'h1);
      apb(1'b0, 8'h90, 32'h0);
      check({31'h0, rerr}, 32'h1);
      wr(8'h01, 32'hfc);
      rdc(ra(`IDX_DIR), 32'h0);
      lfsr_r = lfsr_next(lfsr_r);
      wr(ra(`IDX_DIR), {24'h0, lfsr_r[7:2], 2'b00});
      rdc(ra(`IDX_DIR), {24'h0, lfsr_r[7:2], 2'b00});
      wr(ra(`IDX_DIR), 32'h0);
      wr(ra(`IDX_CNT_HI), 32'h1234);
      rdc(ra(`IDX_CNT_HI), 32'h0);
      tst <= 1'b1;
      lfsr_r = lfsr_next(lfsr_r);
      wr(ra(`IDX_CNT_HI), {16'h0, lfsr_r});
      rdc(ra(`IDX_CNT_HI), {16'h0, lfsr_r});
      wr(ra(`IDX_SCTL1), 32'h80);
      pair(16'h3);
      frz <= 1'b1;
      pair(16'h3);
      wr(ra(`IDX_SCTL1), 32'ha0);
      pair(16'h0);
      frz <= 1'b0;
      wai <= 1'b1;
      wr(ra(`IDX_SCTL1), 32'hc0);
      pair(16'h0);
      wr(ra(`IDX_SCTL1), 32'h80);
      pair(16'h3);
      wai <= 1'b0;
      stop <= 1'b1;
      pair(16'h0);
      stop <= 1'b0;
      wr(ra(`IDX_SCTL1), 32'h00);
      pair(16'h0);
      wr(ra(`IDX_CNT_HI), 32'hfff0);
      wr(ra(`IDX_SCTL2), 32'h80);
      wr(ra(`IDX_SCTL1), 32'h80);
      repeat (30) @(posedge ref_clk_i);
      wr(ra(`IDX_SCTL1), 32'h00);
      rdc(ra(`IDX_OVF_FLG), 32'h80);
      check(32'(irq), 32'h1);
      wr(ra(`IDX_SCTL2), 32'h00);
      repeat (2) @(negedge ref_clk_i);
      check(32'(irq), 32'h0);
      wr(ra(`IDX_SCTL2), 32'h80);
      wr(ra(`IDX_OVF_FLG), 32'h80);
      repeat (2) @(negedge ref_clk_i);
      check(32'(irq), 32'h0);
      rdc(ra(`IDX_OVF_FLG), 32'h0);
      lfsr_r = lfsr_next(lfsr_r);
      v = lfsr_r;
      wr(ra(`IDX_CNT_HI), {16'h0, v});
      wr(ra(`IDX_EDG_LO), 32'h10);
      i_pins.pulse(0, 1);
      rdc(tc_addr(2), {16'h0, v});
      rdc(ra(`IDX_CH_FLG), 32'h04);
      wr(ra(`IDX_CH_FLG), 32'h04);
      wr(ra(`IDX_DIR), 32'h08);
      wr(ra(`IDX_ACT_LO), 32'hc0);
      wr(ra(`IDX_FORCE), 32'h08);
      @(negedge ref_clk_i);
      check({30'h0, pin_oe[1], pin_out[1]}, 32'h3);
      wr(ra(`IDX_ACT_LO), 32'h40);
      wr(ra(`IDX_FORCE), 32'h08);
      @(negedge ref_clk_i);
      check(32'(pin_out[1]), 32'h0);
      rdc(ra(`IDX_CH_FLG), 32'h0);
      wr(ra(`IDX_DIR), 32'h18);
      wr(ra(`IDX_ACT_HI), 32'h03);
      wr(tc_addr(4), {16'h0, v + 16'h10});
      wr(ra(`IDX_SCTL1), 32'h80);
      repeat (40) @(posedge ref_clk_i);
      wr(ra(`IDX_SCTL1), 32'h00);
      check(32'(pin_out[2]), 32'h1);
      rdc(ra(`IDX_CH_FLG), 32'h10);
      wr(ra(`IDX_DIR), 32'h9c);
      wr(ra(`IDX_OVR_MASK), 32'h04);
      wr(ra(`IDX_OVR_DATA), 32'h04);
      wr(ra(`IDX_FORCE), 32'h80);
      @(negedge ref_clk_i);
      check(32'(pin_out[0]), 32'h1);
      wr(ra(`IDX_DIR), 32'h00);
      wr(ra(`IDX_PA_CTL), 32'h50);
      lfsr_r = lfsr_next(lfsr_r);
      i_pins.pulse(5, int'(lfsr_r[2:0]) + 1);
      rdc(ra(`IDX_PA_HI), 32'(lfsr_r[2:0]) + 32'h1);
      check(32'(pin_oe[5]), 32'h0);
      rdc(ra(`IDX_PA_FLG), 32'h01);
      wr(ra(`IDX_DIR), 32'h80);
      wr(ra(`IDX_ACT_HI), 32'hc3);
      repeat (2) @(negedge ref_clk_i);
      check(32'(pin_oe[5]), 32'h0);
      wr(ra(`IDX_PA_CTL), 32'h00);
      repeat (2) @(negedge ref_clk_i);
      check(32'(pin_oe[5]), 32'h1);
      final_report();
   end
endmodule

// ==== tb/timer_cc_props.sv ====
// Port-level assertions for the capture/compare timer
`timescale 1ns/1ps
module timer_cc_props #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Modes and pins
   input wire logic stop_mode_i,
   input wire logic [5:0] ch_pin_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   wire logic setup_w = psel_i && !penable_i;
   wire logic bad_w = (paddr_i[1:0] != 2'h0) || (paddr_i[7:2] inside {[6'h10:6'h13]}) || (paddr_i[7:2] > 6'h23);
   sequence setup_s;
      setup_w;
   endsequence
   sequence answer_s;
      pready_o ##1 !pready_o;
   endsequence
   AST_READY: assert property (setup_s |=> answer_s) else $error("no single ready after setup");
   AST_READY_CAUSE: assert property (pready_o |-> $past(setup_w)) else $error("ready without setup");
   AST_ERR_BAD: assert property (setup_w && bad_w && !pwrite_i |=> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped read not refused");
   AST_ERR_GOOD: assert property (setup_w && !bad_w |=> !pslverr_o) else $error("mapped access refused");
   AST_ERR_ONLY_READY: assert property (pslverr_o |-> pready_o) else $error("error outside answer");
   AST_FORCE_READ_ZERO: assert property (setup_w && !pwrite_i && paddr_i == 8'h04 |=> prdata_o == 32'h0)
      else $error("force register reads nonzero");
   AST_RDATA_HOLD: assert property (pready_o && !setup_w |=> $stable(prdata_o)) else $error("read data moved");
   AST_STOP_HOLD: assert property (stop_mode_i && !psel_i |=> $stable(ch_pin_o)) else $error("pins move in stop");
endmodule

bind timer_cc timer_cc_props #(.ADDR_W(ADDR_W)) i_props (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .stop_mode_i(stop_mode_i), .ch_pin_o(ch_pin_o));
